// [hdl/host_port.sv]
// Asynchronous host bus port with compressed-data queue and service request.
// Assumes host pins are asynchronous to mclk_in; the pad ring resolves the
// data bus from data_oe_out. The codec core fills (encode) or drains (decode).
//
// Operation
// (R1) Strobes count only while chip select low
// (R2) Data bus released while chip select high
// (R3) Writes take effect at write strobe rise
// (R4) Reads drive register while read strobe low
// (R5) Acknowledge low marks each completed access
// (R6) Non-data registers wait one cycle first
// (R7) Decode: full queue holds acknowledge high
// (R8) Encode: empty queue holds acknowledge high
// (R9) Active-high queue service request output
// (R10) Request on near-full encode, near-empty decode
// (R11) Request and status low without condition
// (R12) Status mirrors request; mask drives interrupt
// (R13) Two address lines select four registers
// (R14) Queue advances only after upper half access
// (R15) Host pins synchronised before any use
`default_nettype none
module host_port #(
   parameter int DEPTH      = host_port_pkg::QUEUE_DEPTH,
   parameter int NEAR_FULL  = host_port_pkg::NEAR_FULL_LVL,
   parameter int NEAR_EMPTY = host_port_pkg::NEAR_EMPTY_LVL
) (
   input  wire logic                             mclk_in,
   input  wire logic                             reset_n_in,
   input  wire logic                             cs_n_in,
   input  wire logic                             wr_n_in,
   input  wire logic                             rd_n_in,
   input  wire logic [host_port_pkg::ADR_W-1:0]  adr_in,
   input  wire logic [host_port_pkg::HALF_N-1:0] host_half_enables_n_in,
   input  wire logic [host_port_pkg::DATA_W-1:0] data_in,
   output var  logic [host_port_pkg::DATA_W-1:0] data_out,
   output var  logic                             data_oe_out,
   output var  logic                             ack_n_out,
   output var  logic                             queue_service_request_out,
   output var  logic                             host_interrupt_request_out,
   output var  logic                             encode_mode_out,
   input  wire logic                             core_fill_valid_in,
   input  wire logic [host_port_pkg::DATA_W-1:0] core_fill_data_in,
   output var  logic                             core_fill_ready_out,
   output var  logic                             core_drain_valid_out,
   output var  logic [host_port_pkg::DATA_W-1:0] core_drain_data_out,
   input  wire logic                             core_drain_ready_in
);
   localparam int DW = host_port_pkg::DATA_W;
   localparam int HW = host_port_pkg::HALF_W;
   localparam int AW = host_port_pkg::ADR_W;
   localparam int BW = host_port_pkg::HALF_N;
   localparam int SW = 3 + AW + BW + DW;
   localparam int CW = $clog2(DEPTH+1);
   localparam logic [CW-1:0] NEAR_FULL_C  = CW'(NEAR_FULL);
   localparam logic [CW-1:0] NEAR_EMPTY_C = CW'(NEAR_EMPTY);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_STALL,
      ST_ACK
   } acc_state_e;

   acc_state_e      state_r;
   logic [SW-1:0]   sync1_r;
   logic [SW-1:0]   sync2_r;
   logic            s_cs_n;
   logic            s_wr_n;
   logic            s_rd_n;
   logic [AW-1:0]   s_adr;
   logic [BW-1:0]   s_be_n;
   logic [DW-1:0]   s_data;
   logic            is_write_r;
   logic [AW-1:0]   adr_r;
   logic [BW-1:0]   be_n_r;
   logic [DW-1:0]   wdata_r;
   logic [HW-1:0]   half_hold_r;
   logic            mask_srq_r;
   logic            encode_r;
   logic [DW-1:0]   scratch_r;
   logic            srq_r;
   logic            start;
   logic            released;
   logic            stall;
   logic            commit;
   logic            commit_cdata;
   logic            upper_done;
   logic [DW-1:0]   push_word;
   logic [DW-1:0]   read_word;

   queue_if #(.WIDTH(DW), .DEPTH(DEPTH)) q ();

   word_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_queue (
      .mclk_in    (mclk_in),
      .reset_n_in (reset_n_in),
      .q          (q)
   );

   // Two-stage synchroniser for every host pin
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync1_r <= {3'h7, {AW{1'b0}}, {BW{1'b1}}, {DW{1'b0}}};
         sync2_r <= {3'h7, {AW{1'b0}}, {BW{1'b1}}, {DW{1'b0}}};
      end else begin
         sync1_r <= {cs_n_in, wr_n_in, rd_n_in, adr_in,
                     host_half_enables_n_in, data_in};      // [R15]
         sync2_r <= sync1_r;                                 // [R15]
      end
   end

   assign {s_cs_n, s_wr_n, s_rd_n, s_adr, s_be_n, s_data} = sync2_r;

   // Access start and end seen on the synchronised strobes
   assign start    = !s_cs_n && (!s_wr_n || !s_rd_n);        // [R1]
   assign released = s_cs_n || (s_wr_n && s_rd_n);

   // Queue stall: full during decode writes, empty during encode reads
   always_comb begin
      stall = 1'b0;
      if (adr_r == host_port_pkg::REG_CDATA) begin
         if (is_write_r && !encode_r && !q.fill_ready) begin
            stall = 1'b1;                                    // [R7]
         end
         if (!is_write_r && encode_r && !q.drain_valid) begin
            stall = 1'b1;                                    // [R8]
         end
      end
   end

   // Access sequencer driving the acknowledge
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  if (s_adr != host_port_pkg::REG_CDATA) begin
                     state_r <= ST_WAIT;                     // [R6]
                  end else begin
                     state_r <= ST_STALL;
                  end
               end
            end
            ST_WAIT: begin
               state_r <= released ? ST_IDLE : ST_ACK;       // [R6]
            end
            ST_STALL: begin
               if (released) begin
                  state_r <= ST_IDLE;
               end else if (!stall) begin
                  state_r <= ST_ACK;                         // [R7] [R8]
               end
            end
            ST_ACK: begin
               if (released) begin
                  state_r <= ST_IDLE;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Latch the kind, address and half enables of each access
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         is_write_r <= 1'b0;
         adr_r      <= '0;
         be_n_r     <= '1;
      end else if (state_r == ST_IDLE && start) begin
         is_write_r <= !s_wr_n;
         adr_r      <= s_adr;                                // [R13]
         be_n_r     <= s_be_n;
      end
   end

   // Write data held while strobe low, before the rising edge is seen
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wdata_r <= host_port_pkg::ZERO_WORD;
      end else if (!s_wr_n && !s_cs_n) begin
         wdata_r <= s_data;                                  // [R3]
      end
   end

   // Commit on strobe release after acknowledge
   assign commit       = (state_r == ST_ACK) && released;    // [R3] [R5]
   assign commit_cdata = commit && (adr_r == host_port_pkg::REG_CDATA);
   assign upper_done   = !be_n_r[host_port_pkg::HALF_HI];    // [R14]

   // Lower half kept until the upper half completes the word
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         half_hold_r <= host_port_pkg::ZERO_HALF;
      end else if (commit_cdata && is_write_r
                   && !be_n_r[host_port_pkg::HALF_LO]) begin
         half_hold_r <= wdata_r[HW-1:0];
      end
   end

   assign push_word = {wdata_r[DW-1:HW],
                       be_n_r[host_port_pkg::HALF_LO] ? half_hold_r : wdata_r[HW-1:0]};

   // Queue direction follows the mode: host fills on decode, drains on encode
   assign q.fill_valid  = encode_r ? core_fill_valid_in
                                   : (commit_cdata && is_write_r && upper_done); // [R14]
   assign q.fill_data   = encode_r ? core_fill_data_in : push_word;
   assign q.drain_ready = encode_r ? (commit_cdata && !is_write_r && upper_done) // [R14]
                                   : core_drain_ready_in;
   assign core_fill_ready_out  = encode_r && q.fill_ready;
   assign core_drain_valid_out = !encode_r && q.drain_valid;
   assign core_drain_data_out  = q.drain_data;

   // Register writes with per-half enables
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         mask_srq_r <= host_port_pkg::MASK_RST;
         encode_r   <= host_port_pkg::ENC_RST;
         scratch_r  <= host_port_pkg::ZERO_WORD;
      end else if (commit && is_write_r) begin              // [R3]
         case (adr_r)
            host_port_pkg::REG_IMASK: begin
               if (!be_n_r[host_port_pkg::HALF_LO]) begin
                  mask_srq_r <= wdata_r[host_port_pkg::IMASK_SRQ_BIT];
               end
            end
            host_port_pkg::REG_MODE: begin
               if (!be_n_r[host_port_pkg::HALF_LO]) begin
                  encode_r <= wdata_r[host_port_pkg::MODE_ENC_BIT];
               end
            end
            host_port_pkg::REG_SCRATCH: begin
               if (!be_n_r[host_port_pkg::HALF_LO]) begin
                  scratch_r[HW-1:0] <= wdata_r[HW-1:0];
               end
               if (!be_n_r[host_port_pkg::HALF_HI]) begin
                  scratch_r[DW-1:HW] <= wdata_r[DW-1:HW];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Read multiplexer over the four registers
   always_comb begin
      read_word = host_port_pkg::ZERO_WORD;
      case (adr_r)
         host_port_pkg::REG_CDATA: begin
            read_word = encode_r ? q.drain_data : host_port_pkg::ZERO_WORD;
         end
         host_port_pkg::REG_IMASK: begin
            read_word[host_port_pkg::IMASK_SRQ_BIT] = mask_srq_r;
            read_word[host_port_pkg::ISTAT_SRQ_BIT] = srq_r;  // [R12]
         end
         host_port_pkg::REG_MODE: begin
            read_word[host_port_pkg::MODE_ENC_BIT] = encode_r;
         end
         host_port_pkg::REG_SCRATCH: begin
            read_word = scratch_r;
         end
         default: begin
            read_word = host_port_pkg::ZERO_WORD;
         end
      endcase
   end

   // Read data loaded as the acknowledge goes low
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         data_out <= host_port_pkg::ZERO_WORD;
      end else if (!is_write_r && !released
                   && (state_r == ST_WAIT || (state_r == ST_STALL && !stall))) begin
         data_out <= read_word;                              // [R4]
      end
   end

   // Bus drive only while selected and read strobe low
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         data_oe_out <= 1'b0;
      end else begin
         data_oe_out <= (state_r == ST_ACK || (state_r == ST_STALL && !stall)
                         || state_r == ST_WAIT)
                        && !is_write_r && !s_cs_n && !s_rd_n; // [R2] [R4]
      end
   end

   // Acknowledge low while the access is complete and still held
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ack_n_out <= 1'b1;
      end else begin
         case (state_r)
            ST_WAIT: begin
               ack_n_out <= released;                        // [R5] [R6]
            end
            ST_STALL: begin
               ack_n_out <= released || stall;               // [R7] [R8]
            end
            ST_ACK: begin
               ack_n_out <= released;                        // [R5]
            end
            default: begin
               ack_n_out <= 1'b1;
            end
         endcase
      end
   end

   // Service request from the fill level, by mode
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         srq_r <= 1'b0;
      end else if (encode_r) begin
         srq_r <= (q.level >= NEAR_FULL_C);                  // [R9] [R10] [R11]
      end else begin
         srq_r <= (q.level <= NEAR_EMPTY_C);                 // [R10] [R11]
      end
   end

   assign queue_service_request_out = srq_r;                 // [R9]

   // Masked interrupt from the mirrored status bit
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         host_interrupt_request_out <= 1'b0;
      end else begin
         host_interrupt_request_out <= srq_r && mask_srq_r;  // [R12]
      end
   end

   assign encode_mode_out = encode_r;
endmodule
`default_nettype wire

// [hdl/host_port_pkg.sv]
// Constants shared by the host port and its compressed-data queue.
// Assumes a single 200 MHz core clock; host pins are asynchronous.
`default_nettype none
package host_port_pkg;
   localparam int DATA_W         = 32;
   localparam int HALF_W         = 16;
   localparam int ADR_W          = 2;
   localparam int HALF_N         = 2;
   localparam int QUEUE_DEPTH    = 8;
   localparam int NEAR_FULL_LVL  = 6;
   localparam int NEAR_EMPTY_LVL = 2;

   // Register indexes on the two address lines, byte address is four times
   localparam logic [1:0] REG_CDATA  = 2'h0;
   localparam logic [1:0] REG_IMASK  = 2'h1;
   localparam logic [1:0] REG_MODE   = 2'h2;
   localparam logic [1:0] REG_SCRATCH = 2'h3;
   localparam logic [7:0] BYTE_ADDR_STEP = 8'h04;

   // Field positions
   localparam int IMASK_SRQ_BIT  = 0;
   localparam int ISTAT_SRQ_BIT  = 8;
   localparam int MODE_ENC_BIT   = 0;
   localparam int HALF_LO        = 0;
   localparam int HALF_HI        = 1;

   // Reset values
   localparam logic [DATA_W-1:0] ZERO_WORD   = 32'h0000_0000;
   localparam logic [HALF_W-1:0] ZERO_HALF   = 16'h0000;
   localparam logic              MASK_RST    = 1'b0;
   localparam logic              ENC_RST     = 1'b0;
endpackage
`default_nettype wire

// [hdl/queue_if.sv]
// Carrier between the host port and its word queue.
// Assumes both ends run on the same core clock.
`default_nettype none
interface queue_if #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
);
   logic                       fill_valid;
   logic                       fill_ready;
   logic [WIDTH-1:0]           fill_data;
   logic                       drain_valid;
   logic                       drain_ready;
   logic [WIDTH-1:0]           drain_data;
   logic [$clog2(DEPTH+1)-1:0] level;

   modport store (
      input  fill_valid, fill_data, drain_ready,
      output fill_ready, drain_valid, drain_data, level
   );
   modport user (
      output fill_valid, fill_data, drain_ready,
      input  fill_ready, drain_valid, drain_data, level
   );
endinterface
`default_nettype wire

// [hdl/word_fifo.sv]
// Flip-flop word queue with valid/ready on both sides.
// Assumes fill and drain share the core clock.
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic mclk_in,
   input  wire logic reset_n_in,
   queue_if.store    q
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [PW-1:0] LAST_C  = PW'(DEPTH-1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0]    wr_ptr_r;
   logic [PW-1:0]    rd_ptr_r;
   logic [CW-1:0]    count_r;
   logic             push;
   logic             pop;

   // Honest full and empty from the count
   assign q.fill_ready  = (count_r != DEPTH_C);
   assign q.drain_valid = (count_r != '0);
   assign q.drain_data  = mem_r[rd_ptr_r];
   assign q.level       = count_r;
   assign push = q.fill_valid & q.fill_ready;
   assign pop  = q.drain_valid & q.drain_ready;

   // Storage written by index
   always_ff @(posedge mclk_in) begin
      if (push) begin
         mem_r[wr_ptr_r] <= q.fill_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == LAST_C) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == LAST_C) ? '0 : rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/host_bus_model.sv]
// Host processor model on the asynchronous bus, one access at a time.
// Assumes an active-low acknowledge and no pull on the data lines.
`default_nettype none
module host_bus_model (
   input  wire logic        clk_in,
   input  wire logic        ack_n_in,
   input  wire logic        dev_oe_in,
   input  wire logic [31:0] dev_data_in,
   output var  logic        cs_n_out,
   output var  logic        wr_n_out,
   output var  logic        rd_n_out,
   output var  logic [1:0]  adr_out,
   output var  logic [1:0]  be_n_out,
   output wire logic [31:0] bus_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] d_r;
   logic        drv_r;

   // Released lines show the inverse of the last value
   assign bus_out = dev_oe_in ? dev_data_in : (drv_r ? d_r : ~d_r);

   // Idle bus
   initial begin
      cs_n_out = 1'b1;
      wr_n_out = 1'b1;
      rd_n_out = 1'b1;
      adr_out = 2'h0;
      be_n_out = 2'h0;
      d_r = 32'h0000_0000;
      drv_r = 1'b0;
   end

   // Select and strobe, wait for acknowledge, hold, then release
   task automatic access(input logic sel, w, input logic [1:0] a, b,
                         input logic [31:0] d, input int lim, hold,
                         output logic [31:0] q, output logic ok);
      int i;
      @(posedge clk_in);
      cs_n_out <= ~sel;
      adr_out <= a;
      be_n_out <= b;
      d_r <= d;
      drv_r <= w;
      wr_n_out <= ~w;
      rd_n_out <= w;
      ok = 1'b0;
      for (i = 0; i < lim && !ok; i++) begin
         @(posedge clk_in);
         ok = (ack_n_in === 1'b0);
      end
      q = bus_out;
      repeat (hold) @(posedge clk_in);
      cs_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      rd_n_out <= 1'b1;
      drv_r <= 1'b0;
      for (i = 0; i < 20 && ack_n_in !== 1'b1; i++) @(posedge clk_in);
      repeat (3) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

// [tb/host_port_monitor.sv]
// Checker for the host port handshake, service request and interrupt pins.
// Assumes it is bound onto host_port and sees only its top-level ports.
`default_nettype none
module host_port_monitor (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic cs_n_in,
   input wire logic wr_n_in,
   input wire logic rd_n_in,
   input wire logic data_oe_out,
   input wire logic ack_n_out,
   input wire logic queue_service_request_out,
   input wire logic host_interrupt_request_out,
   input wire logic encode_mode_out,
   input wire logic core_fill_ready_out,
   input wire logic core_drain_valid_out
);
   // Access under way on the raw pins
   logic acc_pin;
   assign acc_pin = !cs_n_in && !(wr_n_in && rd_n_in);

   // One clock domain
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (!reset_n_in);

   // Bus, strobe and acknowledge relations
   a_bus_released: assert property (cs_n_in [*5] |-> !data_oe_out)
      else $error("data bus driven while deselected");
   a_idle_no_ack: assert property (cs_n_in [*5] |-> ack_n_out)
      else $error("acknowledge while deselected");
   a_ack_release: assert property ((wr_n_in && rd_n_in) [*5] |-> ack_n_out)
      else $error("acknowledge held after release");
   a_ack_wait: assert property ($fell(ack_n_out) |-> acc_pin && $past(acc_pin, 4))
      else $error("acknowledge without wait cycle");
   a_read_drive: assert property ($rose(data_oe_out) |-> $fell(ack_n_out) && !rd_n_in)
      else $error("read data outside acknowledged read");
   a_write_commit: assert property ($changed(encode_mode_out) |->
      wr_n_in && $past(wr_n_in) && !$past(ack_n_out, 2))
      else $error("register changed before strobe rise");

   // Service request and interrupt relations
   a_srq_decode: assert property ((!encode_mode_out && !core_drain_valid_out) [*3]
      |-> queue_service_request_out)
      else $error("no request on empty decode queue");
   a_srq_encode: assert property ((encode_mode_out && !core_fill_ready_out) [*3]
      |-> queue_service_request_out)
      else $error("no request on full encode queue");
   a_irq_mirror: assert property (host_interrupt_request_out |->
      queue_service_request_out || $past(queue_service_request_out))
      else $error("interrupt without request");
   a_irq_quiet: assert property (!queue_service_request_out [*2] |-> !host_interrupt_request_out)
      else $error("interrupt held without request");

   // Main scenarios
   c_read: cover property ($rose(data_oe_out));
   c_stall: cover property ((acc_pin && ack_n_out) [*8]);
   c_irq: cover property ($rose(host_interrupt_request_out));
endmodule

bind host_port host_port_monitor mon (.mclk_in, .reset_n_in, .cs_n_in, .wr_n_in, .rd_n_in,
   .data_oe_out, .ack_n_out, .queue_service_request_out, .host_interrupt_request_out,
   .encode_mode_out, .core_fill_ready_out, .core_drain_valid_out);
`default_nettype wire

// [tb/host_port_tb_top.sv]
// Bench for the host port: host model on the bus, core side driven here.
// Assumes the package queue depth and thresholds, one 200 MHz clock.
`default_nettype none
module host_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk_in, reset_n_in, cs_n, wr_n, rd_n, oe, ack_n, srq, irq, enc;
   logic        fv, fr, dv, dr, ok, okp;
   logic [1:0]  adr, be_n;
   logic [31:0] bus, dout, fd, dd, q;
   int          n_fail, n_checks, hold;

   host_bus_model host (.clk_in(mclk_in), .ack_n_in(ack_n), .dev_oe_in(oe),
      .dev_data_in(dout), .cs_n_out(cs_n), .wr_n_out(wr_n), .rd_n_out(rd_n),
      .adr_out(adr), .be_n_out(be_n), .bus_out(bus));

   host_port DUT (.mclk_in, .reset_n_in, .cs_n_in(cs_n), .wr_n_in(wr_n), .rd_n_in(rd_n),
      .adr_in(adr), .host_half_enables_n_in(be_n), .data_in(bus), .data_out(dout),
      .data_oe_out(oe), .ack_n_out(ack_n), .queue_service_request_out(srq),
      .host_interrupt_request_out(irq), .encode_mode_out(enc), .core_fill_valid_in(fv),
      .core_fill_data_in(fd), .core_fill_ready_out(fr), .core_drain_valid_out(dv),
      .core_drain_data_out(dd), .core_drain_ready_in(dr));

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Verdict and end of run
   task automatic summarize();
      if (n_fail == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Host access; a refused one must stay unacknowledged
   task automatic acc(input logic w, input logic [1:0] a, b, input logic [31:0] d,
                      input logic ok_exp, input logic sel = 1'b1);
      host.access(sel, w, a, b, d, ok_exp ? 200 : 30, hold, q, ok);
      chk(32'(ok), 32'(ok_exp));
      chk(32'(ack_n), 32'h1);
      if (ok !== ok_exp) summarize();
   endtask

   // Core takes one word in decode
   task automatic pop(input logic [31:0] e);
      int i;
      i = 0;
      do begin
         @(negedge mclk_in);
         i++;
      end while (dv !== 1'b1 && i < 50);
      chk(32'(dv), 32'h1);
      chk(dd, e);
      if (dv !== 1'b1) summarize();
      @(posedge mclk_in);
      dr <= 1'b1;
      @(posedge mclk_in);
      dr <= 1'b0;
   endtask

   // Core offers one word in encode
   task automatic push(input logic [31:0] d, output logic took);
      int i;
      @(posedge mclk_in);
      fv <= 1'b1;
      fd <= d;
      took = 1'b0;
      for (i = 0; i < 20 && !took; i++) begin
         @(negedge mclk_in);
         took = (fr === 1'b1);
      end
      @(posedge mclk_in);
      fv <= 1'b0;
   endtask

   // Idle pins after reset
   task automatic t_reset();
      chk({27'h0, ack_n, oe, srq, irq, enc}, 32'h14);
   endtask

   // Scratch, mask and status registers
   task automatic t_regs();
      acc(1'b1, 2'h3, 2'h0, 32'hA5A5_5A5A, 1'b1);
      acc(1'b1, 2'h3, 2'h1, 32'h1234_1234, 1'b1);
      hold = 3;
      acc(1'b0, 2'h3, 2'h0, 32'h0, 1'b1);
      hold = 0;
      chk(q, 32'h1234_5A5A);
      acc(1'b1, 2'h3, 2'h0, 32'h0, 1'b0, 1'b0);
      acc(1'b0, 2'h3, 2'h0, 32'h0, 1'b1);
      chk(q, 32'h1234_5A5A);
      acc(1'b1, 2'h1, 2'h0, 32'h1, 1'b1);
      chk(32'(irq), 32'h1);
      acc(1'b0, 2'h1, 2'h0, 32'h0, 1'b1);
      chk(q, 32'h101);
      acc(1'b1, 2'h1, 2'h0, 32'h0, 1'b1);
      chk(32'(irq), 32'h0);
   endtask

   // Decode: fill until full, stall, drain in order
   task automatic t_decode();
      int i;
      for (i = 0; i < 8; i++) begin
         acc(1'b1, 2'h0, 2'h0, 32'h1000_0000 | 32'(i), 1'b1);
         chk(32'(srq), 32'(i < 2));
      end
      acc(1'b1, 2'h0, 2'h0, 32'hDEAD_BEEF, 1'b0);
      pop(32'h1000_0000);
      acc(1'b1, 2'h0, 2'h0, 32'h1000_0008, 1'b1);
      for (i = 1; i < 9; i++) pop(32'h1000_0000 | 32'(i));
      repeat (2) @(posedge mclk_in);
      chk(32'(srq), 32'h1);
   endtask

   // Encode: empty stall, core fills until refused, slow host drains
   task automatic t_encode();
      int i;
      acc(1'b1, 2'h2, 2'h0, 32'h1, 1'b1);
      chk(32'(enc), 32'h1);
      acc(1'b0, 2'h0, 2'h0, 32'h0, 1'b0);
      for (i = 0; i < 9; i++) begin
         push(32'h2000_0000 | 32'(i), okp);
         repeat (2) @(posedge mclk_in);
         chk({30'h0, okp, srq}, {30'h0, i < 8, i >= 5});
      end
      hold = 2;
      for (i = 0; i < 8; i++) begin
         acc(1'b0, 2'h0, 2'h0, 32'h0, 1'b1);
         chk(q, 32'h2000_0000 | 32'(i));
      end
      hold = 0;
      acc(1'b0, 2'h0, 2'h0, 32'h0, 1'b0);
   endtask

   // Half-word host: queue moves only on the upper half
   task automatic t_half();
      acc(1'b1, 2'h2, 2'h0, 32'h0, 1'b1);
      acc(1'b1, 2'h0, 2'h2, 32'hBEEF_BEEF, 1'b1);
      chk(32'(dv), 32'h0);
      acc(1'b1, 2'h0, 2'h1, 32'hCAFE_CAFE, 1'b1);
      pop(32'hCAFE_BEEF);
   endtask

   // Clock
   initial begin
      mclk_in = 1'b0;
      forever #2.5 mclk_in = ~mclk_in;
   end

   // Reset, then the scenarios
   initial begin
      reset_n_in = 1'b0;
      fv = 1'b0;
      fd = 32'h0000_0000;
      dr = 1'b0;
      n_fail = 0;
      n_checks = 0;
      hold = 0;
      repeat (8) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
      t_reset();
      t_regs();
      t_decode();
      t_encode();
      t_half();
      summarize();
   end
endmodule
`default_nettype wire
